// ### bts_brake_test_sequencer.sv
`timescale 1ns/10ps
module bts_brake_test_sequencer
   import bts_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC
) (
   // Clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    arst_n,
   // Sequence control
   input  wire logic                    start,
   input  wire logic                    fault_ack,
   input  wire logic                    brake_closed,
   input  wire bts_times_t              times,
   // Controller feedback
   input  wire bts_axis_t               axis,
   // Parameters
   input  wire logic [TRQ_W-1:0]        test_torque_param,
   input  wire logic [TRQ_W-1:0]        weight_torque_param,
   input  wire logic [TRQ_W-1:0]        max_motor_torque,
   input  wire logic [TRQ_W-1:0]        measured_load_torque,
   input  wire logic [7:0]              auto_load_torque_ctrl,
   input  wire logic [7:0]              endstop_mode_param,
   input  wire logic [POS_W-1:0]        position_window_param,
   input  wire logic [POS_W-1:0]        endstop_threshold_param,
   input  wire logic                    endstop_sensor_select,
   input  wire logic [POS_W-1:0]        contour_deviation,
   input  wire logic [POS_W-1:0]        position_offset,
   input  wire logic                    torque_at_limit,
   // Requests and results
   output logic                         test_select,
   output logic                         close_brake_req,
   output logic                         move_axis_req,
   output logic                         done,
   output logic                         error,
   output logic [7:0]                   status,
   output logic                         param_alarm,
   output logic [TRQ_W-1:0]             endstop_torque_limit,
   output logic [TRQ_W-1:0]             limit_centre,
   output logic                         endstop_reached
);
   // The tick divider needs at least two clocks per tick
   if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("TICK_CYCLES must be at least 2");
   end

   bts_state_t             state, next_state;
   logic [TMR_W-1:0]       timer, next_timer;
   logic [31:0]            tick_cnt, next_tick_cnt;
   logic                   next_select, next_close, next_move, next_done, next_error;
   logic [7:0]             next_status;
   logic                   next_alarm, next_reached;
   logic [TRQ_W-1:0]       next_limit, next_centre;
   logic [TRQ_W:0]         need;
   logic [TRQ_W:0]         lim_sum, hold_sum;     // One bit wider so the sums never wrap
   logic [TRQ_W-1:0]       centre, extra;
   logic                   tick, in_test, window_bad, fxs_now, auto_on;

   assign tick    = (tick_cnt == TICK_CYCLES - 1);
   assign auto_on = auto_load_torque_ctrl[CTRL_AUTO_BIT];
   assign in_test = (state != S_IDLE) && (state != S_FAULT);
   assign window_bad = in_test && (position_offset > position_window_param); // R7
   // Endstop detection ignores the sensor select on purpose
   assign fxs_now = (contour_deviation > endstop_threshold_param) && torque_at_limit; // R8 R9

   // Torque derivation, computed combinationally, latched at selection
   always_comb begin
      centre = auto_on ? measured_load_torque : weight_torque_param; // R14
      need   = {1'b0, test_torque_param} - {1'b0, measured_load_torque}; // R10
      if (need[TRQ_W]) begin
         extra = '0;
      end else if (need[TRQ_W-1:0] > max_motor_torque) begin
         extra = max_motor_torque; // R11
      end else begin
         extra = need[TRQ_W-1:0];
      end
      lim_sum  = {1'b0, extra} + {1'b0, centre}; // R12
      hold_sum = {1'b0, extra} + {1'b0, weight_torque_param}; // R13
   end

   // Sequencer next state
   always_comb begin
      next_state    = state;
      next_timer    = timer;
      next_tick_cnt = tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
      next_select   = test_select;
      next_close    = close_brake_req;
      next_move     = move_axis_req;
      next_done     = done;
      next_error    = error;
      next_status   = status;
      next_alarm    = param_alarm;
      next_limit    = endstop_torque_limit;
      next_centre   = limit_centre;
      next_reached  = fxs_now;
      if (tick && timer != '0) begin
         next_timer = timer - TMR_W'(1);
      end
      unique case (state)
         S_IDLE: begin
            if (start) begin
               next_done = 1'b0;
               next_alarm = 1'b0;
               if (!axis.ext_control) begin
                  next_state = S_FAULT;
                  next_status = ST_NOT_EXT;
               end else if (!axis.start_ok || !endstop_mode_param[MODE_TEST_BIT]) begin // R16
                  next_state = S_FAULT;
                  next_status = ST_START;
               end else if (!auto_on && (hold_sum < {1'b0, test_torque_param})) begin
                  next_alarm = 1'b1; // R13
                  next_state = S_FAULT;
                  next_status = ST_NO_ACTIVE;
               end else begin
                  next_select = 1'b1; // R1
                  next_centre = centre; // R12 R14
                  // Saturate: a wrapped sum would load the brake with a tiny limit
                  next_limit  = lim_sum[TRQ_W] ? '1 : lim_sum[TRQ_W-1:0]; // R12
                  next_timer  = times.test_active_timeout;
                  next_tick_cnt = 32'h0000_0000;
                  next_state  = S_SELECT;
               end
            end
         end
         S_SELECT: begin
            if (axis.test_active) begin // R1
               next_close = 1'b1; // R2
               next_timer = times.brake_close_timeout;
               next_tick_cnt = 32'h0000_0000;
               next_state = S_CLOSE;
            end else if (timer == '0) begin
               next_state = S_FAULT;
               next_status = ST_NO_ACTIVE;
            end
         end
         S_CLOSE: begin
            if (brake_closed) begin // R2
               next_move = 1'b1; // R3
               next_timer = times.feed_cmd_timeout;
               next_tick_cnt = 32'h0000_0000;
               next_state = S_FEED;
            end else if (timer == '0) begin
               next_state = S_FAULT;
               next_status = ST_NO_CLOSED;
            end
         end
         S_FEED: begin
            if (axis.feed_plus || axis.feed_minus) begin // R3
               next_timer = times.endstop_timeout;
               next_tick_cnt = 32'h0000_0000;
               next_state = S_REACH;
            end else if (timer == '0) begin
               next_state = S_FAULT;
               next_status = ST_NO_FEED;
            end
         end
         S_REACH: begin
            if (axis.axis_reset) begin
               next_state = S_FAULT;
               next_status = ST_NOT_REACH;
            end else if (endstop_reached) begin // R4
               next_timer = times.hold_time;
               next_tick_cnt = 32'h0000_0000;
               next_state = S_HOLD;
            end else if (timer == '0) begin
               next_state = S_FAULT;
               next_status = ST_FXS_TMO; // R4
            end
         end
         S_HOLD: begin
            if (!endstop_reached) begin
               next_state = S_FAULT;
               next_status = ST_OPENS; // R5
            end else if (timer == '0) begin
               next_select = 1'b0; // R6
               next_close = 1'b0;
               next_move = 1'b0;
               next_timer = times.test_active_timeout;
               next_tick_cnt = 32'h0000_0000;
               next_state = S_DESEL;
            end
         end
         S_DESEL: begin
            if (!axis.test_active) begin // R6
               next_done = 1'b1;
               next_state = S_IDLE;
            end else if (timer == '0) begin
               next_state = S_FAULT;
               next_status = ST_DESELECT;
            end
         end
         S_FAULT: begin
            next_error = 1'b1; // R17
            next_close = 1'b0;
            next_move = 1'b0;
            next_select = 1'b0;
            if (fault_ack && error) begin // R17
               next_error = 1'b0;
               next_status = ST_OK;
               next_state = S_IDLE;
            end
         end
         default: begin
            next_state = S_FAULT;
            next_status = ST_INTERNAL; // R15
         end
      endcase
      // Leaving the window overrides any step; brake is not holding
      if (window_bad && state != S_FAULT) begin // R7
         next_state = S_FAULT;
         next_status = ST_NOT_HOLD;
      end
      if (next_state == S_FAULT) begin // R17
         next_close = 1'b0;
         next_move = 1'b0;
         next_select = 1'b0;
      end
   end

   // Registers
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= S_IDLE;
         timer <= '0;
         tick_cnt <= 32'h0000_0000;
         test_select <= 1'b0;
         close_brake_req <= 1'b0;
         move_axis_req <= 1'b0;
         done <= 1'b0;
         error <= 1'b0;
         status <= ST_OK;
         param_alarm <= 1'b0;
         endstop_torque_limit <= '0;
         limit_centre <= '0;
         endstop_reached <= 1'b0;
      end else begin
         state <= next_state;
         timer <= next_timer;
         tick_cnt <= next_tick_cnt;
         test_select <= next_select;
         close_brake_req <= next_close;
         move_axis_req <= next_move;
         done <= next_done;
         error <= next_error;
         status <= next_status;
         param_alarm <= next_alarm;
         endstop_torque_limit <= next_limit;
         limit_centre <= next_centre;
         endstop_reached <= next_reached;
      end
   end
endmodule

// ### bts_ctrl_model.sv
`timescale 1ns/10ps
module bts_ctrl_model
   import bts_pkg::*;
(
   // Clock and requests; mode picks an injected fault
   input  wire logic       sys_clk, arst_n, test_select, close_brake_req, move_axis_req, ext, ok,
   input  wire logic [2:0] mode,
   // Feedback flags
   output bts_axis_t        axis,
   output logic             brake_closed, torque_at_limit,
   output logic [POS_W-1:0] contour_deviation
);
   logic [1:0] sel_d;
   logic [7:0] cnt;
   logic       seen, at_stop;
   // The active flag lags two cycles, slower than the sequencer's own path
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) {sel_d, cnt, seen} <= '0;
      else {sel_d, cnt, seen} <= {sel_d[0], test_select, move_axis_req ? cnt + 8'h01 : 8'h00,
                                  test_select | (seen & mode == 3'h7)};
   end
   // Deviation passes the threshold after a few cycles of motion
   assign at_stop = cnt > 8'h02 && mode != 3'h4 && mode != 3'h6 && !(mode == 3'h5 && cnt > 8'h0a);
   assign axis = '{test_active: mode != 3'h1 && (sel_d[1] || (seen && mode == 3'h7)),
                   feed_plus: move_axis_req && mode != 3'h3, feed_minus: 1'b0, ext_control: ext,
                   axis_reset: mode == 3'h6 && cnt > 8'h04, start_ok: ok};
   assign brake_closed = close_brake_req && mode != 3'h2;
   assign torque_at_limit = move_axis_req;
   assign contour_deviation = at_stop ? 24'h000100 : 24'h000000;
endmodule

// ### bts_pkg.sv
// Behaviour
// (R1) Start selects test; active flag within timeout
// (R2) Close request; brake-closed feedback within timeout
// (R3) Move request; plus or minus command within timeout
// (R4) Endstop-reached flag within endstop timeout
// (R5) Endstop flag stays high whole hold time
// (R6) Deselect, open brake, active drops, done
// (R7) Position window checked from test start
// (R8) Endstop from contour deviation versus threshold
// (R9) Distance exceeds threshold; drive reaches limit
// (R10) Drive supplies braking minus measured torque
// (R11) Drive torque clamped to maximum motor torque
// (R12) Limit equals extra torque plus weight torque
// (R13) Inconsistent torque parameters raise alarm
// (R14) Auto bit: measured torque centres limit
// (R15) Status byte: zero ok, codes 1..11
// (R16) Endstop mode bit 1 enables test
// (R17) Fault drops requests, error held until acknowledge
package bts_pkg;
   localparam int unsigned CLK_HZ    = 100_000_000;
   localparam int unsigned TICK_US   = 1000;
   localparam int unsigned TICK_CYC  = CLK_HZ / 1_000_000 * TICK_US;
   localparam int unsigned TMR_W     = 16;
   localparam int unsigned TRQ_W     = 16;
   localparam int unsigned POS_W     = 24;
   localparam int unsigned MODE_TEST_BIT = 1;
   localparam int unsigned CTRL_AUTO_BIT = 0;
   localparam logic [7:0] ST_OK        = 8'h00;
   localparam logic [7:0] ST_START     = 8'h01;
   localparam logic [7:0] ST_NO_ACTIVE = 8'h02;
   localparam logic [7:0] ST_NO_CLOSED = 8'h03;
   localparam logic [7:0] ST_NO_FEED   = 8'h04;
   localparam logic [7:0] ST_NOT_REACH = 8'h05;
   localparam logic [7:0] ST_FXS_TMO   = 8'h06;
   localparam logic [7:0] ST_NOT_HOLD  = 8'h07;
   localparam logic [7:0] ST_OPENS     = 8'h08;
   localparam logic [7:0] ST_DESELECT  = 8'h09;
   localparam logic [7:0] ST_INTERNAL  = 8'h0a;
   localparam logic [7:0] ST_NOT_EXT   = 8'h0b;

   typedef enum logic [7:0] {
      S_IDLE   = 8'h01,
      S_SELECT = 8'h02,
      S_CLOSE  = 8'h04,
      S_FEED   = 8'h08,
      S_REACH  = 8'h10,
      S_HOLD   = 8'h20,
      S_DESEL  = 8'h40,
      S_FAULT  = 8'h80
   } bts_state_t;

   typedef struct packed {
      logic [TMR_W-1:0] test_active_timeout;
      logic [TMR_W-1:0] brake_close_timeout;
      logic [TMR_W-1:0] feed_cmd_timeout;
      logic [TMR_W-1:0] endstop_timeout;
      logic [TMR_W-1:0] hold_time;
   } bts_times_t;

   typedef struct packed {
      logic             test_active;
      logic             feed_plus;
      logic             feed_minus;
      logic             ext_control;
      logic             axis_reset;
      logic             start_ok;
   } bts_axis_t;
endpackage

// ### bts_sva.sv
`timescale 1ns/10ps
module bts_sva
   import bts_pkg::*;
(
   // Watched ports
   input wire logic             sys_clk, arst_n, start, fault_ack, brake_closed, torque_at_limit,
   input wire bts_axis_t        axis,
   input wire logic [POS_W-1:0] contour_deviation, endstop_threshold_param,
   input wire logic             test_select, close_brake_req, move_axis_req, done, error, endstop_reached,
   input wire logic [7:0]       status
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // Each request rises one cycle after its cause
   a_start_selects: assert property ($rose(test_select) |-> $past(start))
      else $error("select without start");
   a_close_after_active: assert property ($rose(close_brake_req) |-> $past(axis.test_active) && test_select)
      else $error("close request too early");
   a_move_after_closed: assert property ($rose(move_axis_req) |-> $past(brake_closed) && close_brake_req)
      else $error("move request too early");
   a_move_needs_close: assert property (move_axis_req |-> close_brake_req && test_select)
      else $error("move without close");
   // A fault drops requests and holds its code until acknowledged
   a_fault_drops: assert property ($rose(error) |-> !close_brake_req && !move_axis_req && !done)
      else $error("requests left on fault");
   a_error_held: assert property (error && !fault_ack |=> error && $stable(status))
      else $error("error dropped early");
   a_status_code: assert property (error |-> status != ST_OK && status <= ST_NOT_EXT)
      else $error("bad status code");
   a_done_clean: assert property ($rose(done) |-> !$past(axis.test_active) && !test_select && !error)
      else $error("done too early");
   a_reach_cause: assert property (endstop_reached |-> $past(torque_at_limit) &&
      $past(contour_deviation) > $past(endstop_threshold_param))
      else $error("endstop without cause");
   c_done: cover property ($rose(done));
   c_opens: cover property ($rose(error) && status == ST_OPENS);
   c_reach: cover property ($rose(endstop_reached));
endmodule

bind bts_brake_test_sequencer bts_sva u_sva (.sys_clk, .arst_n, .start, .fault_ack, .brake_closed,
   .torque_at_limit, .axis, .contour_deviation, .endstop_threshold_param, .test_select, .close_brake_req,
   .move_axis_req, .done, .error, .endstop_reached, .status);

// ### test_brake_test_sequencer.sv
`timescale 1ns/10ps
module test_brake_test_sequencer
   import bts_pkg::*;
;
   // Inputs at idle values; times in ticks
   logic sys_clk = 1'b0, arst_n = 1'b0, start = 1'b0, fault_ack = 1'b0, ext = 1'b1, ok = 1'b1;
   logic endstop_sensor_select = 1'b0;
   logic [2:0] mode = 3'h0;
   bts_times_t times = {16'h0002, 16'h0002, 16'h0002, 16'h0002, 16'h0003};
   logic [TRQ_W-1:0] test_torque_param = 16'h0100, weight_torque_param = 16'h0100;
   logic [TRQ_W-1:0] max_motor_torque = 16'h0fff, measured_load_torque = 16'h0100;
   logic [7:0] auto_load_torque_ctrl = 8'h00, endstop_mode_param = 8'h02;
   logic [POS_W-1:0] position_window_param = 24'h001000, endstop_threshold_param = 24'h0000ff;
   logic [POS_W-1:0] position_offset = 24'h000000, contour_deviation;
   // Observed signals
   bts_axis_t axis;
   logic brake_closed, torque_at_limit, test_select, close_brake_req, move_axis_req;
   logic done, error, param_alarm, endstop_reached;
   logic [7:0] status;
   logic [TRQ_W-1:0] endstop_torque_limit, limit_centre;
   int n_fail = 0, compares = 0, seed = 41, i, k;
   logic [31:0] r;
   logic [16:0] e;
   logic [7:0] ex [11] = '{ST_NO_ACTIVE, ST_NO_CLOSED, ST_NO_FEED, ST_FXS_TMO, ST_OPENS, ST_NOT_REACH,
                           ST_DESELECT, ST_NOT_EXT, ST_START, ST_START, ST_NOT_HOLD};

   // Short ticks keep every timeout to about eight cycles
   bts_brake_test_sequencer #(.TICK_CYCLES(4)) dut (.sys_clk, .arst_n, .start, .fault_ack, .brake_closed,
      .times, .axis, .test_torque_param, .weight_torque_param, .max_motor_torque, .measured_load_torque,
      .auto_load_torque_ctrl, .endstop_mode_param, .position_window_param, .endstop_threshold_param,
      .endstop_sensor_select, .contour_deviation, .position_offset, .torque_at_limit, .test_select,
      .close_brake_req, .move_axis_req, .done, .error, .status, .param_alarm, .endstop_torque_limit,
      .limit_centre, .endstop_reached);
   bts_ctrl_model model (.sys_clk, .arst_n, .test_select, .close_brake_req, .move_axis_req, .ext, .ok,
      .mode, .axis, .brake_closed, .torque_at_limit, .contour_deviation);

   initial forever #5 sys_clk = ~sys_clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      compares++;
      if (got !== want) begin
         n_fail++;
         $display("mismatch at %0t: got %h want %h", $time, got, want);
      end
   endtask

   task automatic give_verdict();
      $display("compares %0d, n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Expected {alarm, limit}: extra torque clamped, centred on weight or measurement
   function automatic logic [16:0] exp_lim(input logic [15:0] t, w, mx, ms, input logic au);
      logic [15:0] x;
      x = (t > ms) ? t - ms : 16'h0000;
      if (x > mx) x = mx;
      return {!au && (x + w < t), x + (au ? ms : w)};
   endfunction

   // One-cycle start pulse, then a bounded wait for done or error
   task automatic run();
      @(posedge sys_clk);
      start <= 1'b1;
      @(posedge sys_clk);
      start <= 1'b0;
      i = 0;
      do begin
         @(posedge sys_clk);
         #1 i++;
      end while (i < 400 && done !== 1'b1 && error !== 1'b1);
      if (i >= 400) begin
         n_fail++;
         $display("mismatch at %0t: sequencer hung", $time);
         give_verdict();
      end
   endtask

   // Healthy feedback on the same edge as the acknowledge, so the acknowledge lands on a clean axis
   task automatic ack();
      @(posedge sys_clk);
      mode <= 3'h0;
      {ext, ok} <= 2'b11;
      endstop_mode_param <= 8'h02;
      position_offset <= 24'h000000;
      fault_ack <= 1'b1;
      repeat (3) @(posedge sys_clk);
      fault_ack <= 1'b0;
      #1 chk(error, 1'b0);
   endtask

   initial begin
      repeat (20) @(posedge sys_clk);
      arst_n <= 1'b1;
      // Each step starved of feedback in turn, then bad start conditions and a position window breach
      for (k = 0; k < 11; k++) begin
         @(posedge sys_clk);
         mode <= (k < 7) ? 3'(k + 1) : 3'h0;
         {ext, ok} <= {k != 7, k != 8};
         endstop_mode_param <= (k == 9) ? 8'h01 : 8'h02;
         position_offset <= (k == 10) ? 24'h002000 : 24'h000000;
         run();
         chk(status, ex[k]);
         chk({error, close_brake_req, move_axis_req}, 3'b100);
         ack();
         $display("test %0d done", k);
      end
      // Random torques; the clamp and the alarm both turn up
      for (k = 11; k < 21; k++) begin
         @(posedge sys_clk);
         r = $random(seed);
         measured_load_torque <= {4'h0, r[11:0]};
         weight_torque_param <= {4'h0, r[27:16]};
         endstop_sensor_select <= r[31];
         r = $random(seed);
         test_torque_param <= {4'h0, r[11:0]};
         max_motor_torque <= {4'h0, r[27:16]};
         auto_load_torque_ctrl <= {7'h00, r[31]};
         // Corner cases: a clamped drive torque, then a load heavier than parameterised
         if (k == 19) begin
            {measured_load_torque, test_torque_param} <= {16'h0100, 16'h0800};
            {max_motor_torque, auto_load_torque_ctrl} <= {16'h0200, 8'h01};
         end else if (k == 20) begin
            {measured_load_torque, weight_torque_param} <= {16'h0200, 16'h0100};
            {test_torque_param, max_motor_torque} <= {16'h0300, 16'h0fff};
            auto_load_torque_ctrl <= 8'h00;
         end
         run();
         e = exp_lim(test_torque_param, weight_torque_param, max_motor_torque, measured_load_torque,
                     auto_load_torque_ctrl[0]);
         chk(param_alarm, e[16]);
         chk(status, e[16] ? ST_NO_ACTIVE : ST_OK);
         if (e[16]) ack();
         else begin
            chk(done, 1'b1);
            chk(endstop_torque_limit, e[15:0]);
            chk(limit_centre, auto_load_torque_ctrl[0] ? measured_load_torque : weight_torque_param);
         end
         $display("test %0d done", k);
      end
      give_verdict();
   end
endmodule
